//--- rtl/i2c_slave_defines.svh
// constants for the two-wire register access slave
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH

// own slave address after power-up
`define SLAVE_ADDR_DEFAULT 7'h0D

// command byte codes
`define CMD_BLOCK_WRITE    8'hA0
`define CMD_BLOCK_READ     8'hA1
`define CMD_POINTER        8'hB0

// pointer value after reset
`define POINTER_RESET      8'h00

// bit counter value of the last bit in a byte
`define BIT_LAST           3'h7
`define BIT_FIRST          3'h0

// byte counter values
`define COUNT_ZERO         8'h00
`define COUNT_ONE          8'h01
`define STEP_ONE           8'h01

// write fifo shape: register address and data per entry
`define WR_FIFO_WIDTH      16
`define WR_FIFO_DEPTH      8

`endif

//--- rtl/i2c_slave_pkg.sv
// types shared by the two-wire register access slave
package i2c_slave_pkg;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WRITE  = 3'b010,
    ST_ACK    = 3'b011,
    ST_READ   = 3'b100,
    ST_MACK   = 3'b101,
    ST_IGNORE = 3'b110
  } link_state_t;

  // meaning of the next byte in a write transfer
  typedef enum logic [2:0] {
    WM_CMD    = 3'b000,
    WM_PTR    = 3'b001,
    WM_REG    = 3'b010,
    WM_BWCNT  = 3'b011,
    WM_BWDATA = 3'b100,
    WM_BRCNT  = 3'b101,
    WM_DONE   = 3'b110
  } write_mode_t;

endpackage : i2c_slave_pkg

//--- rtl/reg_write_fifo.sv
// shift-register fifo carrying register writes to the user side
`timescale 1ns/1ps
`default_nettype none

module reg_write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  // whole fifo state: entries and their valid flags, head at index 0
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // entry storage
    logic [DEPTH-1:0]            vld;  // entry occupied
  } fifo_state_t;

  fifo_state_t s;       // registered state
  fifo_state_t next_s;  // next state

  // flags straight from the flops: full when the top slot is taken
  assign in_ready  = ~s.vld[DEPTH-1];
  assign out_valid = s.vld[0];
  assign out_data  = s.mem[0];

  // pop shifts everything down, push fills the lowest free slot
  always_comb begin
    logic placed;
    placed = 1'b0;
    next_s = s;
    if (s.vld[0] && out_ready) begin
      // shift only inside the array, top slot empties
      for (int i = 0; i < DEPTH-1; i++) begin
        next_s.mem[i] = s.mem[i+1];
        next_s.vld[i] = s.vld[i+1];
      end
      next_s.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && ~s.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_s.vld[i]) begin
          next_s.mem[i] = in_data;
          next_s.vld[i] = 1'b1;
          placed        = 1'b1;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : reg_write_fifo

`default_nettype wire

//--- rtl/i2c_reg_slave.sv
// two-wire slave giving an outside master access to the register space
//
// Notes on behaviour
// - answer to slave address 0x0D after reset
// - shift eight bits msb first, last is direction
// - pull data low through ninth pulse to acknowledge
// - nine pulses per byte, receiver acknowledges
// - data moves only while clock low; rise stops
// - first written byte is command or register address
// - no commands when reading; prior write sets up
// - read ends with master no-ack then stop
// - decode block write, block read, pointer codes
// - register address then data stores one register
// - pointer command loads pointer from next byte
// - block write takes count then that many bytes
// - plain read returns one byte at pointer
// - block read: count, repeated start, counted bytes
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_defines.svh"

module i2c_reg_slave
  import i2c_slave_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  output var  logic        wr_valid,
  input  wire logic        wr_ready,
  output var  logic [7:0]  wr_addr,
  output var  logic [7:0]  wr_data,
  output var  logic [7:0]  rd_addr,
  input  wire logic [7:0]  rd_data
);

  // whole engine state
  typedef struct packed {
    logic        scl_s1;   // clock sync, first stage
    logic        scl_s2;   // clock sync, second stage
    logic        scl_d;    // clock, one cycle older
    logic        sda_s1;   // data sync, first stage
    logic        sda_s2;   // data sync, second stage
    logic        sda_d;    // data, one cycle older
    link_state_t state;    // serial engine state
    write_mode_t mode;     // what the next written byte means
    logic [2:0]  bit_cnt;  // bits seen in the current byte
    logic        full;     // eight bits done, awaiting clock fall
    logic [7:0]  shreg;    // shift register, both directions
    logic        rw;       // direction of the current transfer
    logic        mack;     // master acknowledged the sent byte
    logic [7:0]  ptr;      // address pointer
    logic [7:0]  reg_addr; // address of a single register write
    logic [7:0]  count;    // block byte counter
    logic        blk_rd;   // block read armed for next read
    logic        push;     // write request into the fifo
    logic [15:0] push_data;// address and data of that request
    logic        oe;       // pulling the data line low
    logic        dout;     // level driven while pulling
  } eng_state_t;

  eng_state_t s;       // registered state
  eng_state_t next_s;  // next state

  logic fifo_in_ready;        // fifo has room
  logic [15:0] fifo_out_data; // head entry

  // line events, from the second sync stage against its one-cycle-older copy
  logic scl_rise;  // clock went high
  logic scl_fall;  // clock went low
  logic start_ev;  // data fell while clock high
  logic stop_ev;   // data rose while clock high

  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign start_ev = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop_ev  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

  // pin outputs straight from flops
  assign sda_oe  = s.oe;
  assign sda_out = s.dout;
  assign rd_addr = s.ptr;
  assign wr_addr = fifo_out_data[15:8];
  assign wr_data = fifo_out_data[7:0];

  // buffer between the serial side and the register side
  reg_write_fifo #(
    .WIDTH (`WR_FIFO_WIDTH),
    .DEPTH (`WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (s.push),
    .in_ready  (fifo_in_ready),
    .in_data   (s.push_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out_data)
  );

  // serial engine: sync, edge events, byte framing and command decode
  always_comb begin
    logic ack;
    ack    = 1'b0;
    next_s = s;
    next_s.push   = 1'b0;
    next_s.dout   = 1'b0;
    // two-stage synchronisers, then one delay for edges
    next_s.scl_s1 = scl_in;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;

    if (start_ev) begin
      // start or repeated start: new address byte follows
      next_s.state   = ST_ADDR;
      next_s.bit_cnt = `BIT_FIRST;
      next_s.full    = 1'b0;
      next_s.mode    = WM_CMD;
      next_s.oe      = 1'b0;
    end else if (stop_ev) begin
      // stop: release the line, drop any armed block read
      next_s.state  = ST_IDLE;
      next_s.mode   = WM_CMD;
      next_s.oe     = 1'b0;
      next_s.blk_rd = 1'b0;
      next_s.full   = 1'b0;
    end else begin
      unique case (s.state)
        ST_IDLE, ST_IGNORE: begin
          // wait for a start; line stays released
          next_s.oe = 1'b0;
        end

        ST_ADDR, ST_WRITE: begin
          // sample on rising clock, msb first
          if (scl_rise) begin
            next_s.shreg   = {s.shreg[6:0], s.sda_s2};
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == `BIT_LAST) begin
              next_s.full = 1'b1;
            end
          end
          // act in the low phase before the ninth pulse
          if (scl_fall && s.full) begin
            next_s.full = 1'b0;
            if (s.state == ST_ADDR) begin
              // address byte: match own address or go quiet
              if (s.shreg[7:1] == `SLAVE_ADDR_DEFAULT) begin
                next_s.rw    = s.shreg[0];
                next_s.oe    = 1'b1;
                next_s.state = ST_ACK;
              end else begin
                next_s.state = ST_IGNORE;
              end
            end else begin
              // written byte: meaning depends on position
              unique case (s.mode)
                WM_CMD: begin
                  ack = 1'b1;
                  if (s.shreg == `CMD_BLOCK_WRITE) begin
                    next_s.mode = WM_BWCNT;
                  end else if (s.shreg == `CMD_BLOCK_READ) begin
                    next_s.mode = WM_BRCNT;
                  end else if (s.shreg == `CMD_POINTER) begin
                    next_s.mode = WM_PTR;
                  end else begin
                    next_s.reg_addr = s.shreg;
                    next_s.mode     = WM_REG;
                  end
                end
                WM_PTR: begin
                  ack         = 1'b1;
                  next_s.ptr  = s.shreg;
                  next_s.mode = WM_DONE;
                end
                WM_REG: begin
                  // one data byte to the addressed register
                  ack = fifo_in_ready;
                  if (fifo_in_ready) begin
                    next_s.push      = 1'b1;
                    next_s.push_data = {s.reg_addr, s.shreg};
                  end
                  next_s.mode = WM_DONE;
                end
                WM_BWCNT: begin
                  ack          = 1'b1;
                  next_s.count = s.shreg;
                  next_s.mode  = (s.shreg == `COUNT_ZERO) ? WM_DONE : WM_BWDATA;
                end
                WM_BWDATA: begin
                  // counted data, pointer relies on prior pointer command
                  ack = fifo_in_ready;
                  if (fifo_in_ready) begin
                    next_s.push      = 1'b1;
                    next_s.push_data = {s.ptr, s.shreg};
                    next_s.ptr       = s.ptr + `STEP_ONE;
                    next_s.count     = s.count - `STEP_ONE;
                    if (s.count == `COUNT_ONE) begin
                      next_s.mode = WM_DONE;
                    end
                  end
                end
                WM_BRCNT: begin
                  // arm a block read for the read after repeated start
                  ack           = 1'b1;
                  next_s.count  = s.shreg;
                  next_s.blk_rd = 1'b1;
                  next_s.mode   = WM_DONE;
                end
                WM_DONE: begin
                  ack = 1'b0;                 // surplus bytes refused
                end
              endcase
              next_s.oe    = ack;
              next_s.state = ST_ACK;
            end
          end
        end

        ST_ACK: begin
          // end of ninth pulse: release, then receive or send
          if (scl_fall) begin
            next_s.bit_cnt = `BIT_FIRST;
            if (s.rw) begin
              // read: commands impossible, pointer set beforehand
              next_s.shreg = rd_data;
              next_s.oe    = ~rd_data[7];
              next_s.state = ST_READ;
            end else begin
              next_s.oe    = 1'b0;
              next_s.state = ST_WRITE;
            end
          end
        end

        ST_READ: begin
          // bits change only on falling clock
          if (scl_rise) begin
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == `BIT_LAST) begin
              next_s.full = 1'b1;
            end
          end
          if (scl_fall) begin
            if (s.full) begin
              // byte sent: release for the master's acknowledge
              next_s.full  = 1'b0;
              next_s.oe    = 1'b0;
              next_s.state = ST_MACK;
              if (s.blk_rd && s.count != `COUNT_ZERO) begin
                next_s.ptr   = s.ptr + `STEP_ONE;
                next_s.count = s.count - `STEP_ONE;
              end
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.oe    = ~s.shreg[6];
            end
          end
        end

        ST_MACK: begin
          // master ack keeps reading, no-ack ends the read
          if (scl_rise) begin
            next_s.mack = ~s.sda_s2;
          end
          if (scl_fall) begin
            if (s.mack) begin
              next_s.shreg   = rd_data;
              next_s.oe      = ~rd_data[7];
              next_s.bit_cnt = `BIT_FIRST;
              next_s.state   = ST_READ;
            end else begin
              next_s.oe    = 1'b0;
              next_s.state = ST_IGNORE;
            end
          end
        end

        default: begin
          // unused code: fall back to idle
          next_s.state = ST_IDLE;
          next_s.oe    = 1'b0;
        end
      endcase
    end
  end

  // state register; the line idles high, so syncs reset high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s        <= '0;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_d  <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_d  <= 1'b1;
      s.ptr    <= `POINTER_RESET;
    end else begin
      s <= next_s;
    end
  end

endmodule : i2c_reg_slave

`default_nettype wire

//--- tb/bus_master.sv
// two-wire bus master model on the far side of the slave
`timescale 1ns/1ps
`default_nettype none

module bus_master (
  input  wire logic clk_sys,
  input  wire logic sda_bus,
  output var  logic scl,
  output var  logic sda_m
);
  // bus idles released, clock stands high
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // wait whole cycles, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // start or repeated start: data falls under a high clock
  task automatic start();
    sda_m = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask : start

  // one pulse; data moves in the low phase only
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_m = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    s = sda_bus;
    scl = 1'b0;
  endtask : bit_io

  // eight bits msb first, ninth pulse released for ack
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send

  // receive a byte, then ack or no-ack
  task automatic recv(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~mack, s);
  endtask : recv

  // data low, clock up, then data rises
  task automatic stop();
    tick(2);
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask : stop
endmodule : bus_master
`default_nettype wire

//--- tb/slave_chk.sv
// assertions on the slave's pins and write port
`timescale 1ns/1ps
`default_nettype none

module slave_chk (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr
);
  logic [4:0] high_cnt;  // cycles with clock high
  logic [4:0] since_oe;  // cycles since data pulled

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // saturating helper counters
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      high_cnt <= 5'h00;
      since_oe <= 5'h1F;
    end else begin
      high_cnt <= !scl_in ? 5'h00 : high_cnt + 5'(high_cnt != 5'h1F);
      since_oe <= sda_oe ? 5'h00 : since_oe + 5'(since_oe != 5'h1F);
    end
  end

  AST_OUT_ZERO: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("pull released early");
  AST_OE_STABLE_HIGH: assert property (high_cnt >= 5'h02 |-> $stable(sda_oe))
    else $error("data moved under high clock");
  AST_IDLE_RELEASED: assert property (high_cnt >= 5'h0C |-> !sda_oe)
    else $error("line held on idle bus");
  AST_PTR_IDLE: assert property (high_cnt >= 5'h0C |-> $stable(rd_addr))
    else $error("pointer moved on idle bus");
  AST_RESET_VALUES: assert property ($rose(reset_n) |-> rd_addr == 8'h00 && !wr_valid)
    else $error("bad state after reset");
  AST_WR_HOLD: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("write entry not held");
  AST_WR_AFTER_ACK: assert property ($rose(wr_valid) |-> since_oe < 5'h10)
    else $error("write without ack");

  // main scenarios seen
  COV_ACK: cover property ($rose(sda_oe));
  COV_TAKE: cover property (wr_valid && wr_ready);
  COV_PTR: cover property ($changed(rd_addr));
endmodule : slave_chk

bind i2c_reg_slave slave_chk slave_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr));
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the register access slave
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_defines.svh"
`define CHK(n, e, g) check(n, 16'(e), 16'(g));

module tb_top;
  localparam logic [6:0] SA = `SLAVE_ADDR_DEFAULT;
  typedef struct packed { logic [7:0] ra; logic [7:0] rd; } row_t;
  logic        clk_sys;
  logic        reset_n;
  logic        wr_ready;
  logic        scl;
  logic        sda_m;
  logic        sda_oe;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  logic [7:0]  mem [256];       // user register space
  logic [15:0] got_q [$];       // writes taken from the fifo
  logic [11:0] acks;
  logic        k;
  logic [7:0]  rb;
  int          mismatches;
  int          samples_checked;
  row_t        rows [4] = '{16'h8512, 16'h00FF, 16'h7F80, 16'hFF01};
  // open-drain line with pull-up
  wire logic       sda_bus = sda_m & ~sda_oe;
  wire logic [7:0] rd_data = mem[rd_addr];

  i2c_reg_slave i2c_reg_slave_inst (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_bus), .sda_out(), .sda_oe(sda_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
  bus_master bus_master_inst (.clk_sys(clk_sys), .sda_bus(sda_bus), .scl(scl), .sda_m(sda_m));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // user side takes fifo entries
  always @(posedge clk_sys) begin
    if (wr_valid === 1'b1 && wr_ready) begin
      got_q.push_back({wr_addr, wr_data});
      mem[wr_addr] <= wr_data;
    end
  end

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction : pat

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // send a byte and compare its ack
  task automatic tx(input logic [7:0] b, input logic e);
    bus_master_inst.send(b, k);
    `CHK("ack", e, k)
  endtask : tx

  // start plus own address
  task automatic go(input logic rw);
    bus_master_inst.start();
    tx({SA, rw}, 1'b1);
  endtask : go

  task automatic set_ptr(input logic [7:0] p);
    go(1'b0);
    tx(`CMD_POINTER, 1'b1);
    tx(p, 1'b1);
    bus_master_inst.stop();
  endtask : set_ptr

  // bounded wait for captured writes
  task automatic wait_q(input int n);
    for (int i = 0; i < 400 && got_q.size() < n; i++) @(posedge clk_sys);
    #1;
  endtask : wait_q

  // watchdog
  initial begin
    repeat (40000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  initial begin
    reset_n  = 1'b0;
    wr_ready = 1'b1;
    foreach (mem[i]) mem[i] = pat(8'(i));
    repeat (20) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    // rows: single write, pointer load, single read back
    foreach (rows[i]) begin
      got_q.delete();
      go(1'b0);
      tx(rows[i].ra, 1'b1);
      tx(rows[i].rd, 1'b1);
      bus_master_inst.stop();
      wait_q(1);
      `CHK("entry", rows[i], got_q[0])
      set_ptr(rows[i].ra);
      `CHK("pointer", rows[i].ra, rd_addr)
      go(1'b1);
      bus_master_inst.recv(1'b0, rb);
      bus_master_inst.stop();
      `CHK("read", rows[i].rd, rb)
    end
    // foreign address ignored
    got_q.delete();
    bus_master_inst.start();
    tx({SA + 7'h01, 1'b0}, 1'b0);
    tx(8'h85, 1'b0);
    tx(8'h12, 1'b0);
    bus_master_inst.stop();
    repeat (30) @(posedge clk_sys);
    `CHK("ignored", 16'h0000, got_q.size())
    // block write across pointer wrap
    set_ptr(8'hFE);
    got_q.delete();
    go(1'b0);
    tx(`CMD_BLOCK_WRITE, 1'b1);
    tx(8'h03, 1'b1);
    for (int j = 0; j < 3; j++) tx(8'hC0 + 8'(j), 1'b1);
    bus_master_inst.stop();
    wait_q(3);
    for (int j = 0; j < 3; j++) `CHK("bw", {8'hFE + 8'(j), 8'hC0 + 8'(j)}, got_q[j])
    `CHK("bw pointer", 8'h01, rd_addr)
    // block read with repeated start
    set_ptr(8'h10);
    go(1'b0);
    tx(`CMD_BLOCK_READ, 1'b1);
    tx(8'h03, 1'b1);
    go(1'b1);
    for (int j = 0; j < 3; j++) begin
      bus_master_inst.recv(j < 2, rb);
      `CHK("br", pat(8'h10 + 8'(j)), rb)
    end
    bus_master_inst.stop();
    `CHK("br pointer", 8'h13, rd_addr)
    // stalled user side fills the fifo
    wr_ready = 1'b0;
    set_ptr(8'h40);
    got_q.delete();
    go(1'b0);
    tx(`CMD_BLOCK_WRITE, 1'b1);
    tx(8'h0C, 1'b1);
    for (int j = 0; j < 12; j++) begin
      bus_master_inst.send(8'(j), k);
      acks[j] = k;
    end
    bus_master_inst.stop();
    `CHK("fill acks", 8'hFF, acks[7:0])
    `CHK("full refused", 1'b0, acks[11])
    wr_ready = 1'b1;
    wait_q(8);
    for (int j = 0; j < 8; j++) `CHK("drain", {8'h40 + 8'(j), 8'(j)}, got_q[j])
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("empty", 1'b0, wr_valid)
    // reset in mid-run
    set_ptr(8'h55);
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("reset pointer", 8'h00, rd_addr)
    `CHK("reset drive", 1'b0, sda_oe)
    reset_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    go(1'b0);
    bus_master_inst.stop();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
